// [core/vfsb_frame_sync.sv]
// frame timing, slip management, tone enables, silence handling and buffer levels
`timescale 1ns/10ps
`default_nettype none
module vfsb_frame_sync
  import vfsb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [CTRL_W-1:0] vocoder_control_register,
  input wire logic full_duplex,
  input wire logic ext_codec,
  input wire logic disc_tx_en,
  input wire logic soft_decision_en,
  input wire logic [2:0] sync_sel,
  input wire logic [2:0] sync_in_frames,
  input wire logic sync_in,
  input wire logic sample_tick,
  input wire logic chan_bit_valid,
  input wire logic chan_hard_bit,
  input wire logic [3:0] soft_bit_likelihood,
  input wire logic enc_frame_done,
  input wire logic enc_nonvoice,
  input wire logic dec_frame_valid,
  input wire logic dec_frame_silent,
  input wire logic [ENV_W-1:0] dec_frame_env,
  input wire logic [GAIN_W-1:0] dec_frame_gain,
  input wire logic dec_sample_valid,
  input wire logic [SAMPLE_W-1:0] dec_sample,
  input wire logic [SAMPLE_W-1:0] mic_sample,
  input wire logic data_wanted_enable,
  input wire logic [WM_W-1:0] low_watermark,
  input wire logic [WM_W-1:0] high_watermark,
  input wire logic [2:0] packet_frames,
  input wire logic packet_written,
  input wire logic frame_taken,
  output logic sync_out,
  output logic sync_oe,
  output logic enc_tone_en,
  output logic dec_tone_en,
  output logic enc_silence_mode,
  output logic comfort_noise_on,
  output logic comfort_start,
  output logic speech_start,
  output logic [ENV_W-1:0] comfort_env,
  output logic [GAIN_W-1:0] comfort_gain,
  output logic metric_valid,
  output logic [3:0] metric,
  output logic hard_bit,
  output logic slip_fix,
  output logic audio_valid,
  output logic [SAMPLE_W-1:0] audio_out,
  output logic enc_sample_valid,
  output logic [SAMPLE_W-1:0] enc_sample,
  output logic data_wanted_flag,
  output logic packet_overrun,
  output logic [OCC_W-1:0] coded_occupancy
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic sync_out;
    logic sync_oe;
    logic [7:0] pulse_cnt;
    logic enc_tone_en;
    logic dec_tone_en;
    logic enc_silence_mode;
    logic comfort_on;
    logic comfort_start;
    logic speech_start;
    logic [ENV_W-1:0] env;
    logic [GAIN_W-1:0] gain;
    logic metric_valid;
    logic [3:0] metric;
    logic hard_bit;
    logic sync_in_d;
    logic drop_dec;
    logic dup_dec;
    logic drop_enc;
    logic dup_enc;
    logic slip_fix;
    logic [AUD_AW-1:0] wr_ptr;
    logic [AUD_AW-1:0] rd_ptr;
    logic [AUD_AW:0] aud_cnt;
    logic tick_d;
    logic pop_d;
    logic aud_valid;
    logic [SAMPLE_W-1:0] aud_out;
    logic enc_valid;
    logic enc_again;
    logic [SAMPLE_W-1:0] enc_sample;
    logic [OCC_W-1:0] occ;
    logic data_wanted;
    logic overrun;
  } vfsb_state_s;

  vfsb_state_s s_r;
  vfsb_state_s s_nxt;
  vfsb_sync_e sync_mode;
  logic [CNT_W-1:0] out_cnt;
  logic [CNT_W-1:0] slip_cnt;
  logic [CNT_W-1:0] out_period;
  logic [CNT_W-1:0] slip_expect;
  logic out_mode;
  logic out_wrap;
  logic sync_edge;
  logic aud_full;
  logic aud_push;
  logic aud_pop;
  logic aud_skip;
  logic [SAMPLE_W-1:0] ram_rdata;
  logic [OCC_W-1:0] pkt_eighths;

  // --------------------------------------------------------------
  // sync pin selection and counters
  // --------------------------------------------------------------
  always_comb begin
    case (sync_sel)
      SYNC_SEL_IN: sync_mode = SYNC_IN;
      SYNC_SEL_8K: sync_mode = SYNC_OUT_8K;
      SYNC_SEL_20: sync_mode = SYNC_OUT_20;
      SYNC_SEL_40: sync_mode = SYNC_OUT_40;
      SYNC_SEL_60: sync_mode = SYNC_OUT_60;
      default: sync_mode = SYNC_IN;
    endcase
  end

  always_comb begin
    case (sync_mode)
      SYNC_OUT_20: out_period = SAMPLES_PER_FRAME;
      SYNC_OUT_40: out_period = CNT_W'(SAMPLES_PER_FRAME * 2);
      SYNC_OUT_60: out_period = CNT_W'(SAMPLES_PER_FRAME * 3);
      default: out_period = CNT_W'(1);
    endcase
  end

  // an external codec's frame sync never reaches here, so the pin stays undriven
  assign out_mode = (sync_mode != SYNC_IN) && !ext_codec;
  assign out_wrap = out_mode && sample_tick && (out_cnt >= out_period);
  assign sync_edge = (sync_mode == SYNC_IN) && sync_in && !s_r.sync_in_d;
  assign slip_expect = CNT_W'(sync_in_frames) * SAMPLES_PER_FRAME;

  vfsb_tick_counter #(.W(CNT_W)) u_out_ctr (
    .clk(clk),
    .rstn(rstn),
    .clr(out_wrap || !out_mode),
    .inc(sample_tick && out_mode),
    .count(out_cnt)
  );

  vfsb_tick_counter #(.W(CNT_W)) u_slip_ctr (
    .clk(clk),
    .rstn(rstn),
    .clr(sync_edge),
    .inc(sample_tick),
    .count(slip_cnt)
  );

  // --------------------------------------------------------------
  // audio output buffer
  // --------------------------------------------------------------
  assign aud_full = (s_r.aud_cnt == AUD_DEPTH);
  assign aud_push = dec_sample_valid && !aud_full;
  assign aud_pop = sample_tick && !s_r.dup_dec && (s_r.aud_cnt != '0);
  assign aud_skip = !sample_tick && s_r.drop_dec && (s_r.aud_cnt != '0);

  vfsb_sample_ram u_ram (
    .clk(clk),
    .wr_en(aud_push),
    .wr_addr(s_r.wr_ptr),
    .wr_data(dec_sample),
    .rd_addr(s_r.rd_ptr),
    .rd_data(ram_rdata)
  );

  assign pkt_eighths = OCC_W'(packet_frames) * FRAME_EIGHTHS;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.comfort_start = 1'b0;
    s_nxt.speech_start = 1'b0;
    s_nxt.metric_valid = 1'b0;
    s_nxt.slip_fix = 1'b0;
    s_nxt.aud_valid = 1'b0;
    s_nxt.enc_valid = 1'b0;
    s_nxt.overrun = 1'b0;
    s_nxt.sync_in_d = sync_in;

    // the full-duplex variant cannot carry tone frames in either direction
    s_nxt.enc_tone_en = vocoder_control_register[CTRL_ENC_TONE_BIT] && !full_duplex;
    s_nxt.dec_tone_en = vocoder_control_register[CTRL_DEC_TONE_BIT_A]
                        && vocoder_control_register[CTRL_DEC_TONE_BIT_B]
                        && !full_duplex;

    // sync output: pulse restarts on each reference event
    s_nxt.sync_oe = out_mode;
    if (out_wrap) begin
      s_nxt.sync_out = 1'b1;
      s_nxt.pulse_cnt = SYNC_PULSE_CYC - 8'h01;
    end else if (s_r.pulse_cnt != 8'h00) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt - 8'h01;
    end else begin
      s_nxt.sync_out = 1'b0;
    end
    if (!out_mode) begin
      s_nxt.sync_out = 1'b0;
      s_nxt.pulse_cnt = 8'h00;
    end

    // channel bits to decoder metrics
    if (chan_bit_valid) begin
      s_nxt.metric_valid = 1'b1;
      if (soft_decision_en) begin
        s_nxt.metric = soft_bit_likelihood;
      end else begin
        s_nxt.metric = chan_hard_bit ? LIKELY_ONE : LIKELY_ZERO;
      end
      s_nxt.hard_bit = s_nxt.metric[3];
    end

    // encoder silence frames follow the activity decision frame by frame
    if (enc_frame_done) begin
      s_nxt.enc_silence_mode = disc_tx_en && enc_nonvoice;
    end

    // decoder frame classification
    if (dec_frame_valid) begin
      if (disc_tx_en && dec_frame_silent) begin
        s_nxt.comfort_start = 1'b1;
        s_nxt.comfort_on = 1'b1;
        s_nxt.env = dec_frame_env;
        s_nxt.gain = dec_frame_gain;
      end else begin
        s_nxt.speech_start = 1'b1;
        s_nxt.comfort_on = 1'b0;
      end
    end

    // decode path: duplicate by not popping, drop by skipping one entry
    s_nxt.tick_d = sample_tick;
    s_nxt.pop_d = aud_pop;
    if (sample_tick && s_r.dup_dec) begin
      s_nxt.dup_dec = 1'b0;
    end
    if (aud_skip) begin
      s_nxt.drop_dec = 1'b0;
    end
    if (aud_pop || aud_skip) begin
      s_nxt.rd_ptr = s_r.rd_ptr + AUD_AW'(1);
    end
    if (aud_push) begin
      s_nxt.wr_ptr = s_r.wr_ptr + AUD_AW'(1);
    end
    s_nxt.aud_cnt = s_r.aud_cnt + (AUD_AW+1)'(aud_push) - (AUD_AW+1)'(aud_pop || aud_skip);
    if (s_r.tick_d) begin
      s_nxt.aud_valid = 1'b1;
      if (s_r.pop_d) begin
        s_nxt.aud_out = ram_rdata;
      end
    end

    // encode path: drop swallows one tick, duplicate sends the sample twice
    if (s_r.enc_again) begin
      s_nxt.enc_valid = 1'b1;
      s_nxt.enc_again = 1'b0;
    end
    if (sample_tick) begin
      if (s_r.drop_enc) begin
        s_nxt.drop_enc = 1'b0;
      end else begin
        s_nxt.enc_valid = 1'b1;
        s_nxt.enc_sample = mic_sample;
        if (s_r.dup_enc) begin
          s_nxt.enc_again = 1'b1;
          s_nxt.dup_enc = 1'b0;
        end
      end
    end

    // slip check, one correction at most per pulse, a new pulse replaces the old one;
    // it sits after both paths so a new request wins over one consumed this cycle
    if (sync_edge) begin
      s_nxt.drop_dec = 1'b0;
      s_nxt.dup_dec = 1'b0;
      s_nxt.drop_enc = 1'b0;
      s_nxt.dup_enc = 1'b0;
      if (slip_cnt == slip_expect + CNT_W'(1)) begin
        s_nxt.drop_dec = 1'b1;
        s_nxt.drop_enc = 1'b1;
        s_nxt.slip_fix = 1'b1;
      end else if (slip_cnt + CNT_W'(1) == slip_expect) begin
        s_nxt.dup_dec = 1'b1;
        s_nxt.dup_enc = 1'b1;
        s_nxt.slip_fix = 1'b1;
      end
    end

    // coded input buffer level; a packet that would overflow is refused
    if (packet_written) begin
      if (s_r.occ + pkt_eighths <= CODED_BUF_EIGHTHS) begin
        s_nxt.occ = s_r.occ + pkt_eighths;
      end else begin
        s_nxt.overrun = 1'b1;
      end
    end
    if (frame_taken && s_nxt.occ >= FRAME_EIGHTHS) begin
      s_nxt.occ = s_nxt.occ - FRAME_EIGHTHS;
    end

    // watermarks compare directly in eighths of a millisecond
    if (!data_wanted_enable) begin
      s_nxt.data_wanted = 1'b0;
    end else if (s_r.occ > OCC_W'(high_watermark)) begin
      s_nxt.data_wanted = 1'b0;
    end else if (s_r.occ <= OCC_W'(low_watermark)) begin
      s_nxt.data_wanted = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.aud_out <= SAMPLE_RST;
      s_r.occ <= OCC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign sync_out = s_r.sync_out;
  assign sync_oe = s_r.sync_oe;
  assign enc_tone_en = s_r.enc_tone_en;
  assign dec_tone_en = s_r.dec_tone_en;
  assign enc_silence_mode = s_r.enc_silence_mode;
  assign comfort_noise_on = s_r.comfort_on;
  assign comfort_start = s_r.comfort_start;
  assign speech_start = s_r.speech_start;
  assign comfort_env = s_r.env;
  assign comfort_gain = s_r.gain;
  assign metric_valid = s_r.metric_valid;
  assign metric = s_r.metric;
  assign hard_bit = s_r.hard_bit;
  assign slip_fix = s_r.slip_fix;
  assign audio_valid = s_r.aud_valid;
  assign audio_out = s_r.aud_out;
  assign enc_sample_valid = s_r.enc_valid;
  assign enc_sample = s_r.enc_sample;
  assign data_wanted_flag = s_r.data_wanted;
  assign packet_overrun = s_r.overrun;
  assign coded_occupancy = s_r.occ;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_enc_tone_gate: assert property (
    !vocoder_control_register[CTRL_ENC_TONE_BIT] || full_duplex |=> !s_r.enc_tone_en)
    else $error("encoder tone enable without its control bit");
  a_dec_tone_gate: assert property (
    vocoder_control_register[CTRL_DEC_TONE_BIT_A] && vocoder_control_register[CTRL_DEC_TONE_BIT_B]
    && !full_duplex |=> s_r.dec_tone_en)
    else $error("decoder tone enable missing");
  a_ext_codec_quiet: assert property (
    ext_codec |=> !s_r.sync_oe ##1 !s_r.sync_out)
    else $error("sync driven with external codec");
  a_empty_repeat: assert property (
    sample_tick && s_r.aud_cnt == '0 |=> ##1 s_r.aud_valid && $stable(s_r.aud_out))
    else $error("empty buffer did not repeat last sample");
  a_full_discard: assert property (
    dec_sample_valid && aud_full && !aud_pop && !aud_skip |=> s_r.aud_cnt == AUD_DEPTH)
    else $error("sample written into full buffer");
  a_slip_dup_both: assert property (
    sync_edge && slip_cnt + CNT_W'(1) == slip_expect |=> s_r.dup_dec && s_r.dup_enc && s_r.slip_fix)
    else $error("slip duplicate not requested");
  a_one_fix_only: assert property (
    !((s_r.drop_dec && s_r.dup_dec) || (s_r.drop_enc && s_r.dup_enc)))
    else $error("two corrections pending at once");
  a_comfort_path: assert property (
    dec_frame_valid && disc_tx_en && dec_frame_silent
    |=> s_r.comfort_start && !s_r.speech_start && s_r.gain == $past(dec_frame_gain))
    else $error("silence frame not sent to comfort noise");
  a_wanted_above_high: assert property (
    s_r.occ > OCC_W'(high_watermark) |=> !s_r.data_wanted)
    else $error("data wanted above high watermark");
  a_sync_pulse_len: assert property (
    out_wrap && out_mode ##1 out_mode |-> s_r.sync_out && s_r.pulse_cnt == SYNC_PULSE_CYC - 8'h01)
    else $error("sync pulse not started");
endmodule // vfsb_frame_sync
`default_nettype wire

// [core/vfsb_pkg.sv]
// shared constants and types of the vocoder frame sync and buffering block
package vfsb_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SAMPLE_RATE_HZ = 8000;
  localparam int unsigned FRAME_MS = 20;
  localparam int unsigned SYNC_PULSE_NS = 1000;
  localparam int unsigned CNT_W = 10;
  localparam logic [CNT_W-1:0] SAMPLES_PER_FRAME = CNT_W'(SAMPLE_RATE_HZ * FRAME_MS / 1000);
  localparam logic [7:0] SYNC_PULSE_CYC = 8'(SYNC_PULSE_NS * CLK_MHZ / 1000);
  // --------------------------------------------------------------
  // control register fields
  // --------------------------------------------------------------
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned CTRL_ENC_TONE_BIT = 12;
  localparam int unsigned CTRL_DEC_TONE_BIT_A = 7;
  localparam int unsigned CTRL_DEC_TONE_BIT_B = 8;
  // --------------------------------------------------------------
  // soft decision coding
  // --------------------------------------------------------------
  localparam logic [3:0] LIKELY_ZERO = 4'h0;
  localparam logic [3:0] LIKELY_ONE = 4'hf;
  // --------------------------------------------------------------
  // coded data buffer and watermarks, in eighths of a millisecond
  // --------------------------------------------------------------
  localparam int unsigned WM_W = 11;
  localparam int unsigned OCC_W = 12;
  localparam int unsigned EIGHTHS_PER_MS = 8;
  localparam int unsigned CODED_BUF_FRAMES = 5;
  localparam logic [OCC_W-1:0] FRAME_EIGHTHS = OCC_W'(FRAME_MS * EIGHTHS_PER_MS);
  localparam logic [OCC_W-1:0] CODED_BUF_EIGHTHS = OCC_W'(CODED_BUF_FRAMES * FRAME_MS * EIGHTHS_PER_MS);
  localparam logic [OCC_W-1:0] OCC_RST = 12'h000;
  // --------------------------------------------------------------
  // audio output buffer and frame parameters
  // --------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned AUD_AW = 4;
  localparam logic [AUD_AW:0] AUD_DEPTH = 5'h10;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;
  localparam int unsigned ENV_W = 16;
  localparam int unsigned GAIN_W = 8;
  // --------------------------------------------------------------
  // sync pin selection
  // --------------------------------------------------------------
  localparam logic [2:0] SYNC_SEL_IN = 3'h0;
  localparam logic [2:0] SYNC_SEL_8K = 3'h1;
  localparam logic [2:0] SYNC_SEL_20 = 3'h2;
  localparam logic [2:0] SYNC_SEL_40 = 3'h3;
  localparam logic [2:0] SYNC_SEL_60 = 3'h4;
  typedef enum logic [4:0] {
    SYNC_IN = 5'h01,
    SYNC_OUT_8K = 5'h02,
    SYNC_OUT_20 = 5'h04,
    SYNC_OUT_40 = 5'h08,
    SYNC_OUT_60 = 5'h10
  } vfsb_sync_e;
endpackage

// [core/vfsb_sample_ram.sv]
// audio output sample store, one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module vfsb_sample_ram
  import vfsb_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AUD_AW-1:0] wr_addr,
  input wire logic [SAMPLE_W-1:0] wr_data,
  input wire logic [AUD_AW-1:0] rd_addr,
  output logic [SAMPLE_W-1:0] rd_data
);
  typedef struct packed {
    logic [SAMPLE_W-1:0] rdata;
  } vfsb_ram_s;
  vfsb_ram_s s_r;
  vfsb_ram_s s_nxt;
  logic [SAMPLE_W-1:0] mem [0:(1<<AUD_AW)-1];

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = mem[rd_addr];
  end

  // storage has no reset: contents are only read after being written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    s_r <= s_nxt;
  end

  assign rd_data = s_r.rdata;
endmodule // vfsb_sample_ram
`default_nettype wire

// [core/vfsb_tick_counter.sv]
// saturating sample-tick counter with synchronous clear
`timescale 1ns/10ps
`default_nettype none
module vfsb_tick_counter #(
  parameter int unsigned W = 10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic inc,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } vfsb_ctr_s;
  vfsb_ctr_s s_r;
  vfsb_ctr_s s_nxt;

  // a tick landing with the clear is counted, so no sample is lost at a boundary
  always_comb begin
    s_nxt = s_r;
    if (clr) begin
      s_nxt.cnt = inc ? W'(1) : '0;
    end else if (inc && s_r.cnt != '1) begin
      s_nxt.cnt = s_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;
endmodule // vfsb_tick_counter
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the frame sync and buffering block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import vfsb_pkg::*;
;
  logic clk = 1'h0, rstn = 1'h0, full_duplex = 1'h0, ext_codec = 1'h0, disc_tx_en = 1'h0;
  logic soft_decision_en = 1'h0, sync_in, sample_tick = 1'h0, chan_bit_valid = 1'h0;
  logic chan_hard_bit = 1'h0, enc_frame_done = 1'h0, enc_nonvoice = 1'h0, frame_taken = 1'h0;
  logic dec_frame_valid = 1'h0, dec_frame_silent = 1'h0, dec_sample_valid = 1'h0;
  logic packet_written = 1'h0, data_wanted_enable, tick_on = 1'h0;
  logic [CTRL_W-1:0] vocoder_control_register = '0;
  logic [2:0] sync_sel = 3'h0, sync_in_frames = 3'h1, packet_frames = 3'h0;
  logic [3:0] soft_bit_likelihood = 4'h0, metric, m;
  logic [ENV_W-1:0] dec_frame_env = '0, comfort_env;
  logic [GAIN_W-1:0] dec_frame_gain = '0, comfort_gain;
  logic [SAMPLE_W-1:0] dec_sample = '0, mic_sample = 16'h1234, audio_out, enc_sample;
  logic [WM_W-1:0] low_watermark, high_watermark;
  logic sync_out, sync_oe, enc_tone_en, dec_tone_en, enc_silence_mode, comfort_noise_on;
  logic comfort_start, speech_start, metric_valid, hard_bit, slip_fix, audio_valid;
  logic enc_sample_valid, data_wanted_flag, packet_overrun;
  logic [OCC_W-1:0] coded_occupancy;
  logic [9:0] per_ticks = '0;
  logic [4:0] mq[$];
  logic [15:0] aq[$];
  int err_total = 0, check_count = 0, seed = 32'h8f4cadab, tick_per = 8, tcnt = 0, n_fix = 0;
  int n_enc = 0;

  vfsb_frame_sync dut (
    .clk, .rstn, .vocoder_control_register, .full_duplex, .ext_codec, .disc_tx_en,
    .soft_decision_en, .sync_sel, .sync_in_frames, .sync_in, .sample_tick, .chan_bit_valid,
    .chan_hard_bit, .soft_bit_likelihood, .enc_frame_done, .enc_nonvoice, .dec_frame_valid,
    .dec_frame_silent, .dec_frame_env, .dec_frame_gain, .dec_sample_valid, .dec_sample,
    .mic_sample, .data_wanted_enable, .low_watermark, .high_watermark, .packet_frames,
    .packet_written, .frame_taken, .sync_out, .sync_oe, .enc_tone_en, .dec_tone_en,
    .enc_silence_mode, .comfort_noise_on, .comfort_start, .speech_start, .comfort_env,
    .comfort_gain, .metric_valid, .metric, .hard_bit, .slip_fix, .audio_valid, .audio_out,
    .enc_sample_valid, .enc_sample, .data_wanted_flag, .packet_overrun, .coded_occupancy
  );
  vfsb_host_model host (
    .clk, .rstn, .sample_tick, .per_ticks, .sync_in, .data_wanted_enable, .low_watermark,
    .high_watermark
  );

  always #2 clk = ~clk;
  // ------------------------------------------------------------
  // sample ticks, shortened so that frame periods stay short
  // ------------------------------------------------------------
  always @(negedge clk) begin
    tcnt <= (tcnt >= tick_per - 1) ? 0 : tcnt + 1;
    sample_tick <= tick_on && tcnt == 0;
  end
  always @(posedge clk) begin
    if (metric_valid === 1'h1) chk("metric", 32'(mq.pop_front()), {hard_bit, metric});
    if (audio_valid === 1'h1 && aq.size() > 0) chk("audio", aq.pop_front(), audio_out);
    if (slip_fix === 1'h1) n_fix <= n_fix + 1;
    if (enc_sample_valid === 1'h1) n_enc <= n_enc + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pkt(input logic w, input logic [2:0] f, input logic t,
                     input logic [OCC_W-1:0] occ, input logic ovr, input logic dw);
    packet_written = w;
    packet_frames = f;
    frame_taken = t;
    cyc(1);
    packet_written = 1'h0;
    frame_taken = 1'h0;
    chk("occupancy", occ, coded_occupancy);
    chk("overrun", ovr, packet_overrun);
    cyc(1);
    chk("data wanted", dw, data_wanted_flag);
  endtask
  task automatic sync_meas(input logic [2:0] sel, input int per, input int n);
    int w = 0;
    int p = 0;
    tick_per = per;
    sync_sel = sel;
    repeat (2) begin
      for (int k = 0; k < 9000 && sync_out === 1'h1; k++) cyc(1);
      for (int k = 0; k < 9000 && sync_out !== 1'h1; k++) cyc(1);
    end
    for (w = 0; w < 9000 && sync_out === 1'h1; w++) cyc(1);
    for (p = w; p < 9000 && sync_out !== 1'h1; p++) cyc(1);
    chk("pulse width", 250, w);
    chk("sync period", n * per, p);
    chk("sync drive", 1, sync_oe);
  endtask
  task automatic slip(input logic [9:0] per, input int exp, input int n_exp);
    int f0 = 0;
    int e0 = 0;
    per_ticks = per;
    repeat (2) @(posedge sync_in);
    cyc(4);
    f0 = n_fix;
    e0 = n_enc;
    repeat (3) @(posedge sync_in);
    cyc(4);
    chk("slip fixes", exp, n_fix - f0);
    chk("enc samples", n_exp, n_enc - e0);
    chk("enc sample", mic_sample, enc_sample);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(2);
    rstn = 1'h1;
    for (int i = 0; i < 17; i++) begin
      dec_sample_valid = 1'h1;
      dec_sample = 16'($random(seed));
      if (i < 16) aq.push_back(dec_sample);
      cyc(1);
    end
    dec_sample_valid = 1'h0;
    aq.push_back(aq[15]);
    aq.push_back(aq[15]);
    tick_on = 1'h1;
    cyc(160);
    chk("audio left", 0, aq.size());
    for (int i = 0; i < 16; i++) begin
      chan_bit_valid = 1'h1;
      soft_decision_en = i[0];
      soft_bit_likelihood = (i < 2) ? 4'h0 : (i < 4) ? 4'hf : 4'($random(seed));
      chan_hard_bit = i[1];
      m = soft_decision_en ? soft_bit_likelihood : {4{chan_hard_bit}};
      mq.push_back({m[3], m});
      cyc(1);
    end
    chan_bit_valid = 1'h0;
    for (int i = 0; i < 16; i++) begin
      vocoder_control_register = 16'($random(seed));
      vocoder_control_register[12] = i[0];
      vocoder_control_register[8] = i[1];
      vocoder_control_register[7] = i[2];
      full_duplex = i[3];
      cyc(2);
      chk("enc tone", i[0] & ~i[3], enc_tone_en);
      chk("dec tone", i[1] & i[2] & ~i[3], dec_tone_en);
    end
    for (int i = 0; i < 4; i++) begin
      disc_tx_en = i[0];
      dec_frame_silent = i[1];
      enc_nonvoice = i[1];
      dec_frame_env = 16'($random(seed));
      dec_frame_gain = 8'($random(seed));
      dec_frame_valid = 1'h1;
      enc_frame_done = 1'h1;
      cyc(1);
      dec_frame_valid = 1'h0;
      enc_frame_done = 1'h0;
      chk("frame", {i == 3, i != 3, i == 3, i == 3},
          {comfort_start, speech_start, comfort_noise_on, enc_silence_mode});
      if (i == 3) chk("noise", {dec_frame_env, dec_frame_gain}, {comfort_env, comfort_gain});
      cyc(1);
    end
    chk("data wanted", 1, data_wanted_flag);
    pkt(1'h1, 3'h4, 1'h0, 12'h280, 1'h0, 1'h0);
    pkt(1'h1, 3'h1, 1'h0, 12'h320, 1'h0, 1'h0);
    pkt(1'h1, 3'h1, 1'h0, 12'h320, 1'h1, 1'h0);
    pkt(1'h0, 3'h0, 1'h1, 12'h280, 1'h0, 1'h0);
    pkt(1'h0, 3'h0, 1'h1, 12'h1e0, 1'h0, 1'h0);
    pkt(1'h0, 3'h0, 1'h1, 12'h140, 1'h0, 1'h0);
    pkt(1'h0, 3'h0, 1'h1, 12'h0a0, 1'h0, 1'h0);
    pkt(1'h0, 3'h0, 1'h1, 12'h000, 1'h0, 1'h1);
    pkt(1'h1, 3'h2, 1'h1, 12'h0a0, 1'h0, 1'h1);
    sync_meas(SYNC_SEL_8K, 300, 1);
    sync_meas(SYNC_SEL_20, 8, 160);
    sync_meas(SYNC_SEL_40, 8, 320);
    sync_meas(SYNC_SEL_60, 8, 480);
    ext_codec = 1'h1;
    cyc(300);
    chk("external codec", 0, {sync_oe, sync_out});
    ext_codec = 1'h0;
    sync_sel = SYNC_SEL_IN;
    cyc(2);
    chk("input mode", 0, sync_oe);
    slip(10'd161, 3, 480);
    slip(10'd159, 3, 480);
    slip(10'd160, 0, 480);
    slip(10'd162, 0, 486);
    sync_in_frames = 3'h2;
    slip(10'd321, 3, 960);
    end_of_test();
  end
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire

// [verification/vfsb_host_model.sv]
// host model: watermark set-up and sync pulses paced in codec samples
`timescale 1ns/10ps
`default_nettype none
module vfsb_host_model
  import vfsb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sample_tick,
  input wire logic [9:0] per_ticks,
  output logic sync_in,
  output logic data_wanted_enable,
  output logic [WM_W-1:0] low_watermark,
  output logic [WM_W-1:0] high_watermark
);
  logic [9:0] cnt_r = '0;
  logic [2:0] hold_r = '0;
  // ------------------------------------------------------------
  // decode set-up: low under one frame, high at 70 ms
  // ------------------------------------------------------------
  initial begin
    data_wanted_enable = 1'h1;
    low_watermark = 11'h078;
    high_watermark = 11'h230;
  end
  // ------------------------------------------------------------
  // sync pulse every per_ticks samples, zero stops the pulses
  // ------------------------------------------------------------
  always @(negedge clk) begin
    if (!rstn || per_ticks == 10'h000) begin
      cnt_r <= 10'h000;
      hold_r <= 3'h0;
    end else if (sample_tick && cnt_r >= per_ticks - 10'h001) begin
      cnt_r <= 10'h000;
      hold_r <= 3'h4;
    end else begin
      cnt_r <= cnt_r + 10'(sample_tick);
      hold_r <= hold_r - 3'(hold_r != 3'h0);
    end
    sync_in <= (hold_r != 3'h0);
  end
endmodule // vfsb_host_model
`default_nettype wire
